// ### bench/aogc_calibrator_props.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Port checker for the calibration sequencer
// ----------------------------------------------------------------
module aogc_calibrator_props (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic conv_start_out,
    input wire logic [3:0] chan_sel_out,
    input wire logic int_gnd_sel_out,
    input wire logic int_ref_sel_out,
    input wire logic cal_busy_out
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    // Start request while idle, then a quiet gap between conversions
    sequence s_start_write;
        sfr_wr_in && sfr_addr_in == aogc_pkg::ADDR_CAL_CTRL
            && sfr_wdata_in[aogc_pkg::CTRL_START_BIT] && !cal_busy_out;
    endsequence
    sequence s_conv_gap;
        !conv_start_out [*8];
    endsequence

    a_busy_on_start:
    assert property (s_start_write |=> cal_busy_out)
        else $error("busy did not follow a start write");
    a_busy_min_hold:
    assert property ($rose(cal_busy_out) |=> cal_busy_out [*8])
        else $error("busy dropped early");
    a_conv_at_rise:
    assert property ($rose(cal_busy_out) |-> conv_start_out)
        else $error("first conversion not started with busy");
    a_conv_gap_kept:
    assert property (conv_start_out |=> s_conv_gap)
        else $error("conversions too close together");
    a_conv_needs_busy:
    assert property (conv_start_out |-> cal_busy_out)
        else $error("conversion started outside calibration");
    a_gnd_route:
    assert property ($stable(chan_sel_out) |->
        int_gnd_sel_out == (chan_sel_out == aogc_pkg::CHAN_INT_GND))
        else $error("ground route wrong for channel");
    a_ref_route:
    assert property ($stable(chan_sel_out) |->
        int_ref_sel_out == (chan_sel_out == aogc_pkg::CHAN_INT_REF))
        else $error("reference route wrong for channel");
    a_chan_frozen:
    assert property (cal_busy_out && $past(cal_busy_out)
        |-> $stable(chan_sel_out))
        else $error("channel changed during calibration");
endmodule

// ### bench/tb.sv
`timescale 1ns/100ps

module tb;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    logic sfr_wr_in = 1'b0;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic [1:0] clk_div_sel_in = 2'h0;
    logic [1:0] acq_sel_in = 2'h0;
    logic [11:0] conv_result_in = 12'h000;
    logic [7:0] sfr_rdata_out;
    logic conv_start_out;
    logic [3:0] chan_sel_out;
    logic int_gnd_sel_out;
    logic int_ref_sel_out;
    logic cal_mode_out;
    logic cal_busy_out;
    logic [11:0] corrected_out;
    int fail_count = 0;
    int check_count = 0;
    logic [13:0] ofs_t [5] = '{14'h2140, 14'h1EC0, 14'h2000, 14'h2000, 14'h2000};
    logic [13:0] gn_t [5] = '{14'h2000, 14'h2000, 14'h3000, 14'h1000, 14'h3FFF};
    logic [11:0] raw_t [5] = '{12'h064, 12'h064, 12'h800, 12'h800, 12'hFA0};
    logic [11:0] exp_t [5] = '{12'h05A, 12'h06E, 12'h820, 12'h7E0, 12'hFFF};
    logic [7:0] ch_t [4] = '{8'hFF, 8'h0C, 8'h01, 8'h0B};

    // 250 MHz core clock
    always #2 clk_in = ~clk_in;

    aogc_calibrator dut (.clk_in(clk_in), .rstn_in(rstn_in),
        .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
        .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
        .clk_div_sel_in(clk_div_sel_in), .acq_sel_in(acq_sel_in),
        .conv_result_in(conv_result_in), .conv_start_out(conv_start_out),
        .chan_sel_out(chan_sel_out), .int_gnd_sel_out(int_gnd_sel_out),
        .int_ref_sel_out(int_ref_sel_out), .cal_mode_out(cal_mode_out),
        .cal_busy_out(cal_busy_out), .corrected_out(corrected_out));

    // ----------------------------------------------------------------
    // Register access and comparison helpers
    // ----------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Range compare; an unknown never counts as inside
    task automatic chk(input string nm, input logic [15:0] lo,
                       input logic [15:0] hi, input logic [15:0] got);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            fail_count++;
            $display("mismatch %s expected %h..%h seen %h", nm, lo, hi, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        @(negedge clk_in);
        sfr_wr_in = 1'b0;
    endtask

    // Address held two cycles so the registered answer has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        sfr_addr_in = a;
        repeat (2) @(negedge clk_in);
        d = sfr_rdata_out;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(nm, {8'h00, e}, {8'h00, e}, {8'h00, d});
    endtask

    task automatic set_coef(input logic [7:0] a, input logic [13:0] c);
        wr(a, c[7:0]);
        wr(a + 8'h01, {2'h0, c[13:8]});
    endtask

    // Runs one calibration, pokes refused writes mid-cycle, checks result
    task automatic cal(input logic [7:0] ctrl, input logic [1:0] dv,
                       input logic [1:0] aq, input logic [11:0] raw,
                       input int len, input logic [7:0] a,
                       input logic [13:0] clo, input logic [13:0] chi);
        int n;
        logic [7:0] l;
        logic [7:0] h;
        n = 0;
        clk_div_sel_in = dv;
        acq_sel_in = aq;
        conv_result_in = raw;
        wr(aogc_pkg::ADDR_CAL_CTRL, ctrl);
        while (cal_busy_out === 1'b1 && n < 40000) begin
            n++;
            if (n == 3) chk("busy read", {8'h00, ctrl & 8'h36 | 8'h80}, {8'h00, ctrl & 8'h36 | 8'h80}, {8'h00, sfr_rdata_out});
            // Control stays addressed until the busy read has been taken
            sfr_addr_in = (n == 5) ? aogc_pkg::ADDR_CHAN_SEL
                : (n < 4) ? aogc_pkg::ADDR_CAL_CTRL : a;
            sfr_wdata_in = 8'h55;
            sfr_wr_in = (n == 5 || n == 7);
            @(negedge clk_in);
        end
        chk("busy length", len[15:0], len[15:0] + 16'h0002, n[15:0]);
        chk("mode out", {15'h0000, ctrl[2]}, {15'h0000, ctrl[2]}, {15'h0000, cal_mode_out});
        rd_chk("control idle", aogc_pkg::ADDR_CAL_CTRL, ctrl & 8'h36);
        rd(a, l);
        rd(a + 8'h01, h);
        chk("coefficient", {2'h0, clo}, {2'h0, chi}, {2'h0, h[5:0], l});
        $display("test calibration %h done", ctrl);
    endtask

    // Hang guard, about 1.6 times the expected run
    initial begin
        #240000;
        fail_count++;
        $display("mismatch watchdog expected done seen timeout");
        close_out();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clk_in);
        rstn_in = 1'b1;
        rd_chk("ofs lo reset", aogc_pkg::ADDR_OFS_LO, 8'h00);
        rd_chk("ofs hi reset", aogc_pkg::ADDR_OFS_HI, 8'h20);
        rd_chk("gain lo reset", aogc_pkg::ADDR_GAIN_LO, 8'h00);
        rd_chk("gain hi reset", aogc_pkg::ADDR_GAIN_HI, 8'h20);
        rd_chk("control reset", aogc_pkg::ADDR_CAL_CTRL, 8'h00);
        wr(aogc_pkg::ADDR_OFS_HI, 8'hFF);
        rd_chk("ofs hi width", aogc_pkg::ADDR_OFS_HI, 8'h3F);
        wr(aogc_pkg::ADDR_GAIN_LO, 8'hA5);
        rd_chk("gain lo width", aogc_pkg::ADDR_GAIN_LO, 8'hA5);
        wr(8'h80, 8'hFF);
        rd_chk("unmapped", 8'h80, 8'h00);
        $display("test registers done");
        // Offset moves results down or up, gain steepens or flattens
        for (int i = 0; i < 5; i++) begin
            set_coef(aogc_pkg::ADDR_OFS_LO, ofs_t[i]);
            set_coef(aogc_pkg::ADDR_GAIN_LO, gn_t[i]);
            conv_result_in = raw_t[i];
            repeat (2) @(negedge clk_in);
            chk("corrected", {4'h0, exp_t[i]}, {4'h0, exp_t[i]}, {4'h0, corrected_out});
        end
        $display("test correction done");
        // Channel field and internal ground or reference routing
        for (int i = 0; i < 4; i++) begin
            wr(aogc_pkg::ADDR_CHAN_SEL, ch_t[i]);
            repeat (2) @(negedge clk_in);
            chk("channel", {12'h000, ch_t[i][3:0]}, {12'h000, ch_t[i][3:0]}, {12'h000, chan_sel_out});
            chk("gnd route", {15'h0000, ch_t[i][3:0] == 4'hB}, {15'h0000, ch_t[i][3:0] == 4'hB}, {15'h0000, int_gnd_sel_out});
            chk("ref route", {15'h0000, ch_t[i][3:0] == 4'hC}, {15'h0000, ch_t[i][3:0] == 4'hC}, {15'h0000, int_ref_sel_out});
        end
        $display("test channels done");
        set_coef(aogc_pkg::ADDR_OFS_LO, 14'h2000);
        set_coef(aogc_pkg::ADDR_GAIN_LO, 14'h2000);
        cal(8'h25, 2'h0, 2'h0, 12'h010, 14 * 31 * 17 * 2, aogc_pkg::ADDR_OFS_LO, 14'h21FF, 14'h2200);
        chk("chan frozen", 16'h000B, 16'h000B, {12'h000, chan_sel_out});
        chk("offset applied", 16'h0000, 16'h0001, {4'h0, corrected_out});
        set_coef(aogc_pkg::ADDR_OFS_LO, 14'h2000);
        wr(aogc_pkg::ADDR_CHAN_SEL, 8'h0C);
        cal(8'h27, 2'h0, 2'h3, 12'hFA0, 14 * 31 * 20 * 2, aogc_pkg::ADDR_GAIN_LO, 14'h3851, 14'h3852);
        chk("gain applied", 16'h0FFE, 16'h0FFF, {4'h0, corrected_out});
        wr(aogc_pkg::ADDR_CHAN_SEL, 8'h01);
        cal(8'h03, 2'h3, 2'h3, 12'hFA0, 14 * 1 * 20 * 16, aogc_pkg::ADDR_GAIN_LO, 14'h3851, 14'h3852);
        close_out();
    end
endmodule

// Checker rides on every calibrator instance
bind aogc_calibrator aogc_calibrator_props u_props (.clk_in(clk_in),
    .rstn_in(rstn_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
    .sfr_wdata_in(sfr_wdata_in), .conv_start_out(conv_start_out),
    .chan_sel_out(chan_sel_out), .int_gnd_sel_out(int_gnd_sel_out),
    .int_ref_sel_out(int_ref_sel_out), .cal_busy_out(cal_busy_out));

// ### core/aogc_calibrator.sv
`timescale 1ns/100ps

// Notes on behaviour
// - Offset and gain coefficients, 14 bits, split 6+8.
// - Larger offset coefficient pushes results down.
// - Larger gain coefficient steepens the transfer slope.
// - Gain trim covers at least plus/minus 2.5 percent.
// - Mode bit plus channel field set calibration.
// - Code 1011 internal ground, 1100 internal reference.
// - Write 25h starts offset, 27h starts gain.
// - Cycle lasts 14 x clk x averages x (17+acq).
// - Busy high for the whole calibration cycle.
module aogc_calibrator (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic [1:0] clk_div_sel_in,
    input wire logic [1:0] acq_sel_in,
    input wire logic [11:0] conv_result_in,
    output logic conv_start_out,
    output logic [3:0] chan_sel_out,
    output logic int_gnd_sel_out,
    output logic int_ref_sel_out,
    output logic cal_mode_out,
    output logic cal_busy_out,
    output logic [11:0] corrected_out
);

    // --------------------------------------------------------------
    // Register storage
    // --------------------------------------------------------------
    aogc_pkg::aogc_state_t state;
    logic [13:0] ofs_coef;
    logic [13:0] gain_coef;
    logic [13:0] work;
    logic [3:0] chan_sel;
    logic [1:0] avg_sel;
    logic mode_bit;
    logic gain_cal;
    logic [4:0] div_lat;
    logic [4:0] len_lat;
    logic [5:0] average_count;
    logic [3:0] bit_idx;
    logic [5:0] avg_cnt;
    logic [6:0] hit_cnt;

    logic busy;
    logic ctrl_wr;
    logic start;
    logic done;
    logic last_avg;
    logic last_bit;
    logic need_more;
    logic keep;
    logic [6:0] next_hit;
    logic [4:0] next_div;
    logic [5:0] next_average_count;

    assign busy = (state == aogc_pkg::AOGC_RUN);
    assign ctrl_wr = sfr_wr_in && (sfr_addr_in == aogc_pkg::ADDR_CAL_CTRL);
    // Start ignored while busy, so a running cycle is never cut short
    assign start = ctrl_wr && !busy
        && sfr_wdata_in[aogc_pkg::CTRL_START_BIT];

    // --------------------------------------------------------------
    // Lookup of averages and converter clock divide
    // --------------------------------------------------------------
    always_comb begin
        case (sfr_wdata_in[aogc_pkg::CTRL_AVG_LSB +: 2])
            2'h0: next_average_count = aogc_pkg::AVERAGE_COUNT_SEL0;
            2'h1: next_average_count = aogc_pkg::AVERAGE_COUNT_SEL1;
            2'h2: next_average_count = aogc_pkg::AVERAGE_COUNT_SEL2;
            default: next_average_count = aogc_pkg::AVERAGE_COUNT_SEL3;
        endcase
        case (clk_div_sel_in)
            2'h0: next_div = aogc_pkg::CLK_DIV_SEL0;
            2'h1: next_div = aogc_pkg::CLK_DIV_SEL1;
            2'h2: next_div = aogc_pkg::CLK_DIV_SEL2;
            default: next_div = aogc_pkg::CLK_DIV_SEL3;
        endcase
    end

    // --------------------------------------------------------------
    // Correction datapath
    // --------------------------------------------------------------
    logic [13:0] ofs_use;
    logic [13:0] gain_use;
    logic signed [15:0] ofs_d;
    logic signed [15:0] gain_d;
    logic signed [23:0] adj;
    logic signed [39:0] prod;
    logic signed [23:0] scaled;
    logic [11:0] corr;

    // Trial value replaces the coefficient under calibration only
    assign ofs_use = (busy && !gain_cal) ? work : ofs_coef;
    assign gain_use = (busy && gain_cal) ? work : gain_coef;
    assign ofs_d = $signed({2'b00, ofs_use})
        - $signed({2'b00, aogc_pkg::COEF_MID});
    assign gain_d = $signed({2'b00, gain_use})
        - $signed({2'b00, aogc_pkg::COEF_MID});
    // Offset above midscale subtracts, up to about 6 percent
    assign adj = $signed({12'h000, conv_result_in})
        - 24'(ofs_d >>> aogc_pkg::OFS_SHIFT);
    // Gain span of about 3.1 percent each way covers 2.5 percent
    assign prod = 40'(adj) * 40'(gain_d);
    assign scaled = adj + 24'(prod >>> aogc_pkg::GAIN_SHIFT);

    // Clamp to the result range
    always_comb begin
        if (scaled < 24'sd0) begin
            corr = 12'h000;
        end else if (scaled > $signed({12'h000, aogc_pkg::RES_FULL})) begin
            corr = aogc_pkg::RES_FULL;
        end else begin
            corr = scaled[11:0];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            corrected_out <= 12'h000;
        end else begin
            corrected_out <= corr;
        end
    end

    // --------------------------------------------------------------
    // Conversion timer
    // --------------------------------------------------------------
    aogc_conv_timer #(
        .DIV_W(5),
        .CNT_W(5)
    ) u_timer (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .run_in(busy),
        .div_in(div_lat),
        .len_in(len_lat),
        .done_out(done)
    );

    // --------------------------------------------------------------
    // Averaged successive approximation decision
    // --------------------------------------------------------------
    // Offset wants more while result sits above zero; gain wants
    // more while result sits below full scale
    assign need_more = gain_cal ? (corr != aogc_pkg::RES_FULL)
                                : (corr != 12'h000);
    assign next_hit = hit_cnt + {6'h00, need_more};
    assign last_avg = (avg_cnt == average_count - 6'h01);
    assign last_bit = (bit_idx == 4'h0);
    assign keep = ({next_hit, 1'b0} > {2'b00, average_count});

    // Sequencer state
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= aogc_pkg::AOGC_IDLE;
        end else begin
            case (state)
                aogc_pkg::AOGC_IDLE: begin
                    if (start) begin
                        state <= aogc_pkg::AOGC_RUN;
                    end
                end
                aogc_pkg::AOGC_RUN: begin
                    if (done && last_avg && last_bit) begin
                        state <= aogc_pkg::AOGC_IDLE;
                    end
                end
                default: state <= aogc_pkg::AOGC_IDLE;
            endcase
        end
    end

    // Trial word, bit index and averaging counters
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            work <= 14'h0000;
            bit_idx <= 4'h0;
            avg_cnt <= 6'h00;
            hit_cnt <= 7'h00;
        end else if (start) begin
            work <= 14'h2000;
            bit_idx <= 4'(aogc_pkg::CAL_BITS - 1);
            avg_cnt <= 6'h00;
            hit_cnt <= 7'h00;
        end else if (busy && done) begin
            if (last_avg) begin
                if (!keep) begin
                    work[bit_idx] <= 1'b0;
                end
                if (!last_bit) begin
                    work[bit_idx - 4'h1] <= 1'b1;
                    bit_idx <= bit_idx - 4'h1;
                end
                avg_cnt <= 6'h00;
                hit_cnt <= 7'h00;
            end else begin
                avg_cnt <= avg_cnt + 6'h01;
                hit_cnt <= next_hit;
            end
        end
    end

    // Conversion start pulse: one per averaged conversion
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            conv_start_out <= 1'b0;
        end else begin
            conv_start_out <= start
                || (busy && done && !(last_avg && last_bit));
        end
    end

    // --------------------------------------------------------------
    // Control register and channel select writes
    // --------------------------------------------------------------
    // Timing settings latched on any idle control write; writes while busy are dropped
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            avg_sel <= 2'h0;
            mode_bit <= 1'b0;
            gain_cal <= 1'b0;
            average_count <= aogc_pkg::AVERAGE_COUNT_SEL0;
            div_lat <= aogc_pkg::CLK_DIV_SEL0;
            len_lat <= aogc_pkg::CONV_BASE_CLKS;
        end else if (ctrl_wr && !busy) begin
            avg_sel <= sfr_wdata_in[aogc_pkg::CTRL_AVG_LSB +: 2];
            mode_bit <= sfr_wdata_in[aogc_pkg::CTRL_MODE_BIT];
            gain_cal <= sfr_wdata_in[aogc_pkg::CTRL_GAIN_BIT];
            average_count <= next_average_count;
            div_lat <= next_div;
            len_lat <= aogc_pkg::CONV_BASE_CLKS
                + {3'h0, acq_sel_in} + 5'h01;
        end
    end

    // Channel field frozen during a cycle so the input stays put
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            chan_sel <= aogc_pkg::CHAN_RESET;
        end else if (sfr_wr_in && !busy
                     && sfr_addr_in == aogc_pkg::ADDR_CHAN_SEL) begin
            chan_sel <= sfr_wdata_in[3:0];
        end
    end

    // Analog routing outputs
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            chan_sel_out <= aogc_pkg::CHAN_RESET;
            int_gnd_sel_out <= 1'b0;
            int_ref_sel_out <= 1'b0;
            cal_mode_out <= 1'b0;
            cal_busy_out <= 1'b0;
        end else begin
            chan_sel_out <= chan_sel;
            int_gnd_sel_out <= (chan_sel == aogc_pkg::CHAN_INT_GND);
            int_ref_sel_out <= (chan_sel == aogc_pkg::CHAN_INT_REF);
            cal_mode_out <= mode_bit;
            cal_busy_out <= busy || start;
        end
    end

    // --------------------------------------------------------------
    // Coefficient registers
    // --------------------------------------------------------------
    // Software writes are held off while busy; the result wins
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ofs_coef <= aogc_pkg::COEF_RESET;
            gain_coef <= aogc_pkg::COEF_RESET;
        end else if (busy && done && last_avg && last_bit) begin
            if (gain_cal) begin
                gain_coef <= keep ? work : (work & ~14'h0001);
            end else begin
                ofs_coef <= keep ? work : (work & ~14'h0001);
            end
        end else if (sfr_wr_in && !busy) begin
            case (sfr_addr_in)
                aogc_pkg::ADDR_OFS_LO: ofs_coef[7:0] <= sfr_wdata_in;
                aogc_pkg::ADDR_OFS_HI: ofs_coef[13:8] <= sfr_wdata_in[5:0];
                aogc_pkg::ADDR_GAIN_LO: gain_coef[7:0] <= sfr_wdata_in;
                aogc_pkg::ADDR_GAIN_HI: gain_coef[13:8] <= sfr_wdata_in[5:0];
                default: ;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Read data, registered
    // --------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sfr_rdata_out <= 8'h00;
        end else begin
            case (sfr_addr_in)
                aogc_pkg::ADDR_CAL_CTRL:
                    sfr_rdata_out <= {busy, 1'b0, avg_sel, 1'b0, mode_bit,
                                      gain_cal, 1'b0};
                aogc_pkg::ADDR_CHAN_SEL:
                    sfr_rdata_out <= {4'h0, chan_sel};
                aogc_pkg::ADDR_OFS_LO: sfr_rdata_out <= ofs_coef[7:0];
                aogc_pkg::ADDR_OFS_HI:
                    sfr_rdata_out <= {2'b00, ofs_coef[13:8]};
                aogc_pkg::ADDR_GAIN_LO: sfr_rdata_out <= gain_coef[7:0];
                aogc_pkg::ADDR_GAIN_HI:
                    sfr_rdata_out <= {2'b00, gain_coef[13:8]};
                default: sfr_rdata_out <= 8'h00;
            endcase
        end
    end

endmodule

// ### core/aogc_conv_timer.sv
`timescale 1ns/100ps

module aogc_conv_timer #(
    parameter int DIV_W = 5,
    parameter int CNT_W = 5
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic run_in,
    input wire logic [DIV_W-1:0] div_in,
    input wire logic [CNT_W-1:0] len_in,
    output logic done_out
);

    // --------------------------------------------------------------
    // Elaboration checks
    // --------------------------------------------------------------
    if (DIV_W < 5 || CNT_W < 5) begin : g_width_check
        $error("aogc_conv_timer: widths too small for divide 16, 20 clks");
    end

    logic [DIV_W-1:0] pre;
    logic [CNT_W-1:0] cnt;
    logic tick;

    // --------------------------------------------------------------
    // Converter clock prescaler and conversion length counter
    // --------------------------------------------------------------
    assign tick = run_in && (pre == div_in - DIV_W'(1));
    assign done_out = tick && (cnt == len_in - CNT_W'(1));

    // Restarts from zero whenever run drops, so no stale phase
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pre <= '0;
            cnt <= '0;
        end else if (!run_in) begin
            pre <= '0;
            cnt <= '0;
        end else if (tick) begin
            pre <= '0;
            cnt <= done_out ? '0 : cnt + CNT_W'(1);
        end else begin
            pre <= pre + DIV_W'(1);
        end
    end

endmodule

// ### core/aogc_pkg.sv
package aogc_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int COEF_W = 14;
    localparam int COEF_HI_W = 6;
    localparam int COEF_LO_W = 8;
    localparam int RES_W = 12;
    localparam int CHAN_W = 4;
    localparam int CAL_BITS = 14;

    // ----------------------------------------------------------------
    // Special function register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CAL_CTRL = 8'hF5;
    localparam logic [7:0] ADDR_CHAN_SEL = 8'hD8;
    localparam logic [7:0] ADDR_OFS_LO = 8'hF1;
    localparam logic [7:0] ADDR_OFS_HI = 8'hF2;
    localparam logic [7:0] ADDR_GAIN_LO = 8'hF3;
    localparam logic [7:0] ADDR_GAIN_HI = 8'hF4;

    // ----------------------------------------------------------------
    // Calibration control fields
    // ----------------------------------------------------------------
    localparam int CTRL_BUSY_BIT = 7;
    localparam int CTRL_AVG_LSB = 4;
    localparam int CTRL_MODE_BIT = 2;
    localparam int CTRL_GAIN_BIT = 1;
    localparam int CTRL_START_BIT = 0;

    // ----------------------------------------------------------------
    // Channel codes, reset values, correction scaling
    // ----------------------------------------------------------------
    localparam logic [3:0] CHAN_INT_GND = 4'hB;
    localparam logic [3:0] CHAN_INT_REF = 4'hC;
    localparam logic [3:0] CHAN_RESET = 4'h0;
    localparam logic [13:0] COEF_MID = 14'h2000;
    localparam logic [13:0] COEF_RESET = 14'h2000;
    localparam logic [11:0] RES_FULL = 12'hFFF;
    localparam int OFS_SHIFT = 5;
    localparam int GAIN_SHIFT = 18;

    // ----------------------------------------------------------------
    // Converter timing
    // ----------------------------------------------------------------
    localparam logic [4:0] CONV_BASE_CLKS = 5'h10;
    localparam logic [5:0] AVERAGE_COUNT_SEL0 = 6'h01;
    localparam logic [5:0] AVERAGE_COUNT_SEL1 = 6'h0F;
    localparam logic [5:0] AVERAGE_COUNT_SEL2 = 6'h1F;
    localparam logic [5:0] AVERAGE_COUNT_SEL3 = 6'h3F;
    localparam logic [4:0] CLK_DIV_SEL0 = 5'h02;
    localparam logic [4:0] CLK_DIV_SEL1 = 5'h04;
    localparam logic [4:0] CLK_DIV_SEL2 = 5'h08;
    localparam logic [4:0] CLK_DIV_SEL3 = 5'h10;

    typedef enum logic {
        AOGC_IDLE,
        AOGC_RUN
    } aogc_state_t;

endpackage
